// *** fsg_defines.vh ***
// constants for the flash segment guard and debug access block
`ifndef FSG_DEFINES_VH
`define FSG_DEFINES_VH
// boot segment size field codes (low two bits)
`define FSG_BSS_NONE      2'b11
`define FSG_BSS_SMALL     2'b10
`define FSG_BSS_MEDIUM    2'b01
`define FSG_BSS_LARGE     2'b00
// debug channel select codes
`define FSG_CH_PAIR1      2'b11
`define FSG_CH_PAIR2      2'b10
`define FSG_CH_PAIR3      2'b01
`define FSG_CH_RSVD       2'b00
// segment addresses (program counter units, two per instruction word)
`define FSG_VS_BASE       24'h00_0000
`define FSG_BS_BASE       24'h00_0200
`define FSG_BS_END_SMALL  24'h00_0800
`define FSG_BS_END_MEDIUM 24'h00_2000
`define FSG_BS_END_LARGE  24'h00_4000
`define FSG_BS_END_LG16   24'h00_2C00
`define FSG_FLASH_END32   24'h00_5800
`define FSG_FLASH_END16   24'h00_2C00
// segment codes reported for an address
`define FSG_SEG_VECTOR    2'b00
`define FSG_SEG_BOOT      2'b01
`define FSG_SEG_GENERAL   2'b10
`define FSG_SEG_NONE      2'b11
// debug reserved data ram bytes
`define FSG_DBG_RAM_BYTES 16'h0050
`endif

// *** fsg_pin_sync.v ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fsg_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             i_core_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_pin,
  output reg  [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;

  // ----------------------------------------------------------------
  // stage chain; s1 is read only by s2 to contain metastability
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s1_r    <= {WIDTH{1'b0}};
      s2_r    <= {WIDTH{1'b0}};
      s3_r    <= {WIDTH{1'b0}};
      o_level <= {WIDTH{1'b0}};
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a bit only changes once stage two and three agree
      o_level <= (s2_r & s3_r) | (o_level & (s2_r | s3_r));
    end
  end
endmodule // fsg_pin_sync

// *** fsg_guard.v ***
// flash segment guard with serial program and debug pin pair steering
`timescale 1ns/1ps
`include "fsg_defines.vh"
module fsg_guard #(
  parameter SMALL_MEM = 0,  // 1 selects the 16 kbyte memory map
  parameter AW        = 24,
  parameter RAW       = 16
) (
  input  wire           i_core_clk,
  input  wire           i_rst_n,
  input  wire [2:0]     i_boot_segment_size_sel,
  input  wire [7:0]     i_boot_segment_config,
  input  wire [7:0]     i_general_segment_config,
  input  wire [1:0]     i_debug_channel_sel,
  input  wire           i_debug_enable,
  input  wire           i_prog_mode,
  input  wire [2:0]     i_prog_clock_pin,
  input  wire [2:0]     i_prog_data_pin,
  input  wire [AW-1:0]  i_fetch_addr,
  input  wire [RAW-1:0] i_ram_addr,
  input  wire           i_tx_bit,
  input  wire           i_tx_en,
  output reg  [2:0]     o_prog_data_pin,
  output reg  [2:0]     o_prog_data_oe,
  output reg            o_link_clk_level,
  output reg            o_link_clk_rise,
  output reg            o_link_clk_fall,
  output reg            o_link_data,
  output reg            o_link_active,
  output reg            o_chan_error,
  output reg  [2:0]     o_pin_reserved,
  output reg            o_ram_reserved,
  output reg  [1:0]     o_fetch_segment,
  output reg            o_fetch_invalid,
  output reg  [AW-1:0]  o_boot_end,
  output reg  [AW-1:0]  o_flash_end,
  output reg  [7:0]     o_boot_cfg_q,
  output reg  [7:0]     o_general_cfg_q
);
  // ----------------------------------------------------------------
  // memory map overview
  // ----------------------------------------------------------------
  // addresses count in program counter units, two per instruction word,
  // and every boundary below is exclusive:
  //   vector  : 0x000000 up to 0x000200, present in every map
  //   boot    : 0x000200 up to the decoded boot end, empty for code 11
  //   general : boot end up to flash end
  //   beyond  : flagged invalid, there is no secure or ram region here
  // the large boot code is clipped to the flash end on the small map,
  // so that map then carries no general segment at all
  // limitation: bit two of the size code is ignored, both of its values
  // give the same map

  // ----------------------------------------------------------------
  // pair decode function
  // ----------------------------------------------------------------
  // one-hot mask of the selected pair: bit n stands for pair n+1;
  // the reserved code maps to an empty mask so no pin downstream is sampled, driven or reserved
  function [2:0] pair_onehot;
    input [1:0] code;
    begin
      case (code)
        `FSG_CH_PAIR1: pair_onehot = 3'b001;
        `FSG_CH_PAIR2: pair_onehot = 3'b010;
        `FSG_CH_PAIR3: pair_onehot = 3'b100;
        default:       pair_onehot = 3'b000; // reserved code
      endcase
    end
  endfunction

  reg          cfg_loaded_r;
  reg  [2:0]   pair_r;
  reg  [AW-1:0] boot_end_nxt;
  reg          clk_prev_r;
  wire [5:0]   pins_sync;
  wire [2:0]   clk_s;
  wire [2:0]   dat_s;
  wire         sel_clk;
  wire         sel_dat;
  wire         link_on;

  // ----------------------------------------------------------------
  // pin synchronisers for all three pairs
  // ----------------------------------------------------------------
  // both pin groups share one synchroniser instance: clock pins in the
  // low three bits, data pins in the high three bits
  fsg_pin_sync #(.WIDTH(6)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      ({i_prog_data_pin, i_prog_clock_pin}),
    .o_level    (pins_sync)
  );
  assign clk_s = pins_sync[2:0];
  assign dat_s = pins_sync[5:3];

  // ----------------------------------------------------------------
  // boot end decode from the size code
  // ----------------------------------------------------------------
  // combinational so the capture flop below takes it in one cycle; the
  // default branch covers the large code
  always @* begin
    case (i_boot_segment_size_sel[1:0])
      `FSG_BSS_NONE:   boot_end_nxt = `FSG_BS_BASE;
      `FSG_BSS_SMALL:  boot_end_nxt = `FSG_BS_END_SMALL;
      `FSG_BSS_MEDIUM: boot_end_nxt = `FSG_BS_END_MEDIUM;
      default:         boot_end_nxt = (SMALL_MEM != 0) ? `FSG_BS_END_LG16 : `FSG_BS_END_LARGE;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration capture on the first cycle after reset release;
  // capturing late keeps the async-free reset constant-only
  // ----------------------------------------------------------------
  // the captured values never change until the next reset, so a later
  // rewrite of the configuration bytes has no effect on a live map;
  // a reserved channel code leaves the pair mask empty: no pin is sampled
  // or driven and the error flag stays set for the whole session
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_loaded_r    <= 1'b0;
      pair_r          <= 3'b000;
      o_boot_end      <= `FSG_BS_BASE;
      o_flash_end     <= `FSG_FLASH_END32;
      o_boot_cfg_q    <= 8'h00;
      o_general_cfg_q <= 8'h00;
      o_chan_error    <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r    <= 1'b1;
      o_boot_end      <= boot_end_nxt;
      o_flash_end     <= (SMALL_MEM != 0) ? `FSG_FLASH_END16 : `FSG_FLASH_END32;
      o_boot_cfg_q    <= i_boot_segment_config;
      o_general_cfg_q <= i_general_segment_config;
      pair_r          <= pair_onehot(i_debug_channel_sel);
      o_chan_error    <= (i_debug_channel_sel == `FSG_CH_RSVD);
    end
  end

  // ----------------------------------------------------------------
  // segment classification of a fetch address; only three segments
  // exist, anything past flash end is flagged, never a secure area
  // ----------------------------------------------------------------
  // the compare chain relies on vector end <= boot end <= flash end,
  // which every size code satisfies on both memory maps
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_fetch_segment <= `FSG_SEG_NONE;
      o_fetch_invalid <= 1'b0;
    end else if (!cfg_loaded_r) begin
      o_fetch_segment <= `FSG_SEG_NONE;
      o_fetch_invalid <= 1'b0;
    end else if (i_fetch_addr < `FSG_BS_BASE) begin
      o_fetch_segment <= `FSG_SEG_VECTOR;
      o_fetch_invalid <= 1'b0;
    end else if (i_fetch_addr < o_boot_end) begin
      o_fetch_segment <= `FSG_SEG_BOOT;
      o_fetch_invalid <= 1'b0;
    end else if (i_fetch_addr < o_flash_end) begin
      o_fetch_segment <= `FSG_SEG_GENERAL;
      o_fetch_invalid <= 1'b0;
    end else begin
      o_fetch_segment <= `FSG_SEG_NONE;
      o_fetch_invalid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // link pair steering: only the selected pair is sampled or driven
  // ----------------------------------------------------------------
  // latency from a pin to the link outputs is four to five core cycles:
  // three synchroniser stages, the agreement filter and the output flop.
  // data and clock share one synchroniser, so their relative timing is
  // kept; the far side must hold each clock level for two or more
  // core cycles or an edge is lost in the filter
  // trade-off: unselected pairs are still synchronised, which costs a few
  // flops but keeps the steering a plain mask with no multiplexer timing
  assign link_on = cfg_loaded_r && (i_prog_mode || i_debug_enable) && (pair_r != 3'b000);
  assign sel_clk = |(clk_s & pair_r);
  assign sel_dat = |(dat_s & pair_r);

  // ----------------------------------------------------------------
  // link outputs and resource reservation
  // ----------------------------------------------------------------
  // reservation follows the debug enable level one cycle later; the ram flag is
  // a registered compare, so it trails the address by one cycle;
  // the reserved pins are the selected pair, which is already masked
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      clk_prev_r       <= 1'b0;
      o_link_clk_level <= 1'b0;
      o_link_clk_rise  <= 1'b0;
      o_link_clk_fall  <= 1'b0;
      o_link_data      <= 1'b0;
      o_link_active    <= 1'b0;
      o_prog_data_pin  <= 3'b000;
      o_prog_data_oe   <= 3'b000;
      o_pin_reserved   <= 3'b000;
      o_ram_reserved   <= 1'b0;
    end else begin
      clk_prev_r       <= sel_clk;
      o_link_clk_level <= link_on & sel_clk;
      // edges come from the filtered level, so no glitch counts twice
      o_link_clk_rise  <= link_on & sel_clk & ~clk_prev_r;
      o_link_clk_fall  <= link_on & ~sel_clk & clk_prev_r;
      o_link_data      <= link_on & sel_dat;
      o_link_active    <= link_on;
      o_prog_data_pin  <= {3{i_tx_bit}} & pair_r;
      o_prog_data_oe   <= (link_on & i_tx_en) ? pair_r : 3'b000;
      o_pin_reserved   <= (cfg_loaded_r & i_debug_enable) ? pair_r : 3'b000;
      o_ram_reserved   <= cfg_loaded_r & i_debug_enable &
                          (i_ram_addr < `FSG_DBG_RAM_BYTES);
    end
  end
endmodule // fsg_guard

// *** fsg_guard_checker.sv ***
// assertion checker watching the guard ports
`timescale 1ns/1ps
module fsg_guard_checker #(
  parameter SMALL_MEM = 0
) (
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire [2:0]  i_boot_segment_size_sel,
  input wire [1:0]  i_debug_channel_sel,
  input wire        i_debug_enable,
  input wire [23:0] i_fetch_addr,
  input wire [15:0] i_ram_addr,
  input wire [2:0]  o_prog_data_oe,
  input wire [2:0]  o_pin_reserved,
  input wire        o_link_clk_rise,
  input wire        o_link_clk_level,
  input wire        o_chan_error,
  input wire        o_ram_reserved,
  input wire [1:0]  o_fetch_segment,
  input wire        o_fetch_invalid,
  input wire [23:0] o_boot_end
);
  reg  [1:0]  up_r = 2'b00;
  reg  [1:0]  bss_r = 2'b11;
  reg  [1:0]  ch_r = 2'b11;
  wire [23:0] end_w = (bss_r == 2'b11) ? 24'h00_0200 : (bss_r == 2'b10) ? 24'h00_0800 :
                      (bss_r == 2'b01) ? 24'h00_2000 : SMALL_MEM ? 24'h00_2C00 : 24'h00_4000;
  wire [23:0] top_w = SMALL_MEM ? 24'h00_2C00 : 24'h00_5800;
  wire [2:0]  pair_w = {ch_r == 2'b01, ch_r == 2'b10, ch_r == 2'b11};
  // ----
  // capture
  // ----
  // mirrors the one-shot capture; up_r[1] marks the fetch path as live
  always @(posedge i_core_clk) begin
    up_r <= i_rst_n ? {up_r[0], 1'b1} : 2'b00;
    if (i_rst_n && !up_r[0]) begin
      bss_r <= i_boot_segment_size_sel[1:0];
      ch_r <= i_debug_channel_sel;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_boot_end: assert property (up_r[0] |-> o_boot_end == end_w)
    else $error("boot end wrong");
  a_ram_window: assert property (up_r[0] |-> o_ram_reserved ==
    ($past(i_debug_enable) && $past(i_ram_addr) < 16'h0050)) else $error("ram reserve wrong");
  a_vector_low: assert property (up_r[1] && $past(i_fetch_addr) < 24'h00_0200
    |-> o_fetch_segment == 2'b00) else $error("vector segment wrong");
  a_boot_span: assert property (up_r[1] && $past(i_fetch_addr) >= 24'h00_0200
    && $past(i_fetch_addr) < end_w |-> o_fetch_segment == 2'b01) else $error("boot segment wrong");
  a_general_span: assert property (up_r[1] && $past(i_fetch_addr) >= end_w
    && $past(i_fetch_addr) < top_w |-> o_fetch_segment == 2'b10) else $error("general segment wrong");
  a_past_end: assert property (up_r[1] |-> o_fetch_invalid == ($past(i_fetch_addr) >= top_w))
    else $error("flash end wrong");
  a_chan_flag: assert property (up_r[0] |-> o_chan_error == (ch_r == 2'b00))
    else $error("channel flag wrong");
  a_pair_only: assert property (up_r[1] |-> ((o_prog_data_oe | o_pin_reserved) & ~pair_w) == 3'h0)
    else $error("unselected pair used");
  a_rise_edge: assert property (o_link_clk_rise |-> o_link_clk_level && !$past(o_link_clk_level))
    else $error("rise pulse wrong");
endmodule // fsg_guard_checker

// *** fsg_probe.sv ***
// serial probe model driving one clock/data pin pair
`timescale 1ns/1ps
module fsg_probe (
  input  wire [1:0] i_sel,
  output wire [2:0] o_clk,
  output wire [2:0] o_dat
);
  reg        ck = 1'b0;
  reg        dt = 1'b0;
  reg        nz = 1'b0;
  reg        busy = 1'b0;
  wire [2:0] m = {i_sel == 2'b01, i_sel == 2'b10, i_sel == 2'b11};
  // ----
  // pins
  // ----
  // floating lines toggle so a stale level never passes for data
  always #5 nz = ~nz;
  assign o_clk = ({3{ck}} & m) | ({3{nz}} & ~m);
  assign o_dat = busy ? ({3{dt}} & m) | ({3{nz}} & ~m) : {3{nz}};
  // clock idles low between frames; data moves while clock is low
  task send(input [7:0] b);
    integer i;
    begin
      busy = 1'b1;
      for (i = 7; i >= 0; i = i - 1) begin
        dt = b[i];
        #32 ck = 1'b1;
        #32 ck = 1'b0;
      end
      busy = 1'b0;
    end
  endtask
endmodule // fsg_probe

// *** fsg_guard_test.sv ***
// self-checking bench for the flash segment guard
`timescale 1ns/1ps
module fsg_guard_test;
  reg         clk = 1'b0, rst_n = 1'b0, dbg = 1'b0, pm = 1'b0, txe = 1'b0, txb = 1'b1;
  reg  [2:0]  bss = 3'h0;
  reg  [7:0]  bcfg = 8'h00, gcfg = 8'h00;
  reg  [1:0]  ch = 2'h3;
  reg  [23:0] fa = 24'h00_0000;
  reg  [15:0] ra = 16'h0000;
  integer     err_total = 0, total_checks = 0, cyc = 0;
  wire [2:0]  pc, pd, po, oe, rsv;
  wire [1:0]  sg;
  wire [23:0] bend, fend;
  wire [7:0]  bq, gq;
  wire        lvl, rise, fall, dat, act, cer, rres, inv;
  fsg_probe probe_u (.i_sel(ch), .o_clk(pc), .o_dat(pd));
  fsg_guard dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_boot_segment_size_sel(bss),
    .i_boot_segment_config(bcfg), .i_general_segment_config(gcfg), .i_debug_channel_sel(ch),
    .i_debug_enable(dbg), .i_prog_mode(pm), .i_prog_clock_pin(pc), .i_prog_data_pin((oe & po) | (~oe & pd)),
    .i_fetch_addr(fa), .i_ram_addr(ra), .i_tx_bit(txb), .i_tx_en(txe), .o_prog_data_pin(po),
    .o_prog_data_oe(oe), .o_link_clk_level(lvl), .o_link_clk_rise(rise), .o_link_clk_fall(fall),
    .o_link_data(dat), .o_link_active(act), .o_chan_error(cer), .o_pin_reserved(rsv), .o_ram_reserved(rres),
    .o_fetch_segment(sg), .o_fetch_invalid(inv), .o_boot_end(bend), .o_flash_end(fend),
    .o_boot_cfg_q(bq), .o_general_cfg_q(gq));
  // clock and hang guard
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task chk(input string nm, input [23:0] e, input [23:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // reset, then alter config after capture: the change must not stick
  task boot(input [1:0] b, input [1:0] c);
    begin
      @(posedge clk);
      {rst_n, dbg, pm, txe} <= 4'h0;
      txb <= 1'b1;
      bss <= {1'b0, b};
      ch <= c;
      {gcfg, bcfg} <= 16'h3CC3;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bss <= {1'b1, ~b};
      {gcfg, bcfg} <= 16'h0000;
      @(posedge clk);
      #1;
    end
  endtask
  task seg(input [23:0] a, input [1:0] s);
    begin
      @(posedge clk);
      fa <= a;
      @(posedge clk);
      #1 chk("segment", s, sg);
    end
  endtask
  task t_seg(input [1:0] b, input [23:0] e);
    begin
      boot(b, 2'b11);
      chk("boot_end", e, bend);
      chk("flash_end", 24'h00_5800, fend);
      chk("cfg", 24'h00_3CC3, {gq, bq});
      seg(24'h00_01FE, 2'b00);
      seg(e - 24'h00_0002, (b == 2'b11) ? 2'b00 : 2'b01);
      seg(e, 2'b10);
      seg(24'h00_57FE, 2'b10);
      seg(24'h00_5800, 2'b11);
      chk("invalid", 24'h1, inv);
    end
  endtask
  task t_ram;
    begin
      boot(2'b10, 2'b10);
      @(posedge clk);
      dbg <= 1'b1;
      ra <= 16'h004F;
      @(posedge clk);
      ra <= 16'h0050;
      #1 chk("ram_lo", 24'h1, rres);
      @(posedge clk);
      dbg <= 1'b0;
      ra <= 16'h0000;
      #1 chk("ram_hi", 24'h0, rres);
      @(posedge clk);
      #1 chk("ram_off", 24'h0, rres);
    end
  endtask
  // one frame from the probe, then the core drives the data pin back
  task t_link(input [1:0] c, input [2:0] m);
    reg [7:0] got;
    integer   n, nf;
    begin
      boot(2'b01, c);
      n = 0;
      nf = 0;
      got = 8'h00;
      @(posedge clk);
      {dbg, pm} <= 2'b11;
      fork
        probe_u.send(8'hA5);
        repeat (120) begin
          @(posedge clk);
          #1;
          if (rise === 1'b1) begin
            got = {got[6:0], dat};
            n = n + 1;
          end
          if (fall === 1'b1)
            nf = nf + 1;
        end
      join
      chk("bits", (m != 0) ? 8 : 0, n);
      chk("data", (m != 0) ? 8'hA5 : 8'h00, got);
      chk("falls", (m != 0) ? 8 : 0, nf);
      chk("clk_idle", 24'h0, lvl);
      chk("active", m != 0, act);
      chk("reserved", m, rsv);
      chk("chan_err", m == 0, cer);
      @(posedge clk);
      txe <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("oe", m, oe);
      chk("drive", m, po & oe);
      repeat (6) @(posedge clk);
      #1 chk("loop_hi", m != 0, dat);
      @(posedge clk);
      txb <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk("drive_lo", 24'h0, po & oe);
      chk("loop_lo", 24'h0, dat);
    end
  endtask
  initial begin
    t_seg(2'b11, 24'h00_0200);
    t_seg(2'b10, 24'h00_0800);
    t_seg(2'b01, 24'h00_2000);
    t_seg(2'b00, 24'h00_4000);
    t_ram;
    t_link(2'b11, 3'b001);
    t_link(2'b10, 3'b010);
    t_link(2'b01, 3'b100);
    t_link(2'b00, 3'b000);
    end_sim;
  end
  task end_sim;
    begin
      if (err_total == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
endmodule // fsg_guard_test
bind fsg_guard fsg_guard_checker #(.SMALL_MEM(SMALL_MEM)) chk_u (.i_core_clk, .i_rst_n,
  .i_boot_segment_size_sel, .i_debug_channel_sel, .i_debug_enable, .i_fetch_addr, .i_ram_addr,
  .o_prog_data_oe, .o_pin_reserved, .o_link_clk_rise, .o_link_clk_level, .o_chan_error,
  .o_ram_reserved, .o_fetch_segment, .o_fetch_invalid, .o_boot_end);
